// File: ari_map.svh
// Constants for the converter result readout block: channel counts,
// result widths, conversion timing and synchroniser reset pattern.
// Assumes it is included by bare name from the readout module.
`ifndef ARI_MAP_SVH
`define ARI_MAP_SVH

`define ARI_NUM_CH        8
`define ARI_RES_W         18
`define ARI_PAD_W         6
`define ARI_BYTES_PER_CH  3
`define ARI_BYTE_STROBES  24
`define ARI_OSR_MAX_LOG2  6
`define ARI_FIFO_DEPTH    32
`define ARI_CLK_MHZ       50
`define ARI_CONV_BASE_NS  2000
`define ARI_CONV_BASE_CYC ((`ARI_CONV_BASE_NS*`ARI_CLK_MHZ+999)/1000)
`define ARI_SYNC_RST      11'h007

`endif

// File: ari_pkg.sv
// Types shared by the readout block: readout modes and converter states.
// Assumes ari_map.svh sits in the same folder.
package ari_pkg;
  typedef enum logic [1:0] {
    ARI_MODE_WORD   = 2'b00,
    ARI_MODE_BYTE   = 2'b01,
    ARI_MODE_SERIAL = 2'b10
  } ari_mode_t;

  typedef enum logic [1:0] {
    ARI_ST_IDLE = 2'b00,
    ARI_ST_CONV = 2'b01,
    ARI_ST_LOAD = 2'b10
  } ari_state_t;
endpackage : ari_pkg

// File: ari_fifo.sv
// Sample FIFO between the converter core and the averaging filter.
// Assumes a single clock and a power-of-two depth.
`timescale 1ns/1ps
module ari_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Draining side
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push_w;
  logic             pop_w;

  assign push_w        = in_valid_in && in_ready_out;
  assign pop_w         = out_ready_in && out_valid_out;
  assign out_valid_out = cnt_r != '0;
  assign out_data_out  = mem_r[rp_r];
  assign cnt_nxt       = cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r        <= '0;
      in_ready_out <= 1'b1;
    end else begin
      cnt_r        <= cnt_nxt;
      // Ready is registered from the next count, so it falls in the same cycle the count reaches full.
      in_ready_out <= cnt_nxt != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push_w) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop_w) begin
        rp_r <= rp_r + AW'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push_w) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule : ari_fifo

// File: ari_readout.sv
// Result readout of an eight-channel simultaneous-sampling converter:
// conversion sequencing, averaging filter, byte and serial readout.
// Assumes the host pins are asynchronous and that converter samples
// arrive on the system clock in channel order through the FIFO.
//
// Overview of operation
// - Select high, byte select high: byte mode.
// - Each result leaves as three bytes.
// - Byte order input picks MSB-first or LSB-first.
// - Select fall enables bus; strobe fall advances.
// - Channels in sequence, twenty-four strobes total.
// - Byte mode flag: high first strobe, low fourth.
// - Results padded with low zeros to 24 bits.
// - Select high, byte select low: serial mode.
// - Select high: serial lines, flag off, clock ignored.
// - MSB at select fall, 18 clocks per channel.
// - Line A channels 1-8, line B 5-8 then 1-4.
// - Serial flag high for channel one, 18 clocks.
// - Flag also marks channel five on line B.
// - Reads during busy return the previous results.
// - Results load at the same edge busy falls.
// - Oversampling pins latched at busy falling edge.
// - Busy lasts longer as oversampling grows.
// - Oversampled results pass an averaging filter.
// - Convert after both start edges; busy held high.
// - Select low: full-word mode, byte pin ignored.
`timescale 1ns/1ps
`include "ari_map.svh"
module ari_readout #(
  parameter int FIFO_DEPTH    = `ARI_FIFO_DEPTH,
  parameter int CONV_BASE_CYC = `ARI_CONV_BASE_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Converter core samples
  input  wire logic [17:0] conv_data_in,
  input  wire logic        conv_valid_in,
  output logic             conv_ready_out,
  // Conversion control pins
  input  wire logic        conv_start_group_a_in,
  input  wire logic        conv_start_group_b_in,
  input  wire logic [2:0]  oversample_ratio_pins_in,
  output logic             busy_out,
  // Mode pins
  input  wire logic        interface_type_select_in,
  input  wire logic        byte_or_serial_select_in,
  input  wire logic        byte_order_control_in,
  output logic             word_mode_out,
  // Host strobes
  input  wire logic        cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        sclk_in,
  // Byte bus
  output logic [7:0]       byte_bus_out,
  output logic             byte_bus_oe_out,
  // Serial lines
  output logic             serial_out_line_a_out,
  output logic             serial_out_line_b_out,
  output logic             serial_oe_out,
  // First-channel flag
  output logic             first_channel_flag_out,
  output logic             first_channel_flag_oe_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  function automatic ari_pkg::ari_mode_t ari_decode(input logic it,
                                                    input logic bs);
    if (!it) begin
      return ari_pkg::ARI_MODE_WORD;
    end else if (bs) begin
      return ari_pkg::ARI_MODE_BYTE;
    end else begin
      return ari_pkg::ARI_MODE_SERIAL;
    end
  endfunction : ari_decode

  function automatic logic [7:0] ari_pick_byte(input logic [17:0] r,
                                               input logic [1:0]  k,
                                               input logic        msb1st);
    logic [23:0] w;
    logic [1:0]  s;
    w = {r, {`ARI_PAD_W{1'b0}}};
    s = msb1st ? k : 2'h2 - k;
    case (s)
      2'h0:    return w[23:16];
      2'h1:    return w[15:8];
      default: return w[7:0];
    endcase
  endfunction : ari_pick_byte

  function automatic logic ari_bit(input logic [17:0] r,
                                   input logic [4:0]  idx);
    return r[5'd17 - idx];
  endfunction : ari_bit

  // Pin synchronisers: three stages, a level counts once stages two and
  // three agree, which filters single-sample glitches on host strobes.
  localparam int SW = 11;
  logic [SW-1:0] pins_w;
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic [SW-1:0] s3_r;
  logic [SW-1:0] f_r;
  logic [SW-1:0] fp_r;

  assign pins_w = {oversample_ratio_pins_in, byte_order_control_in,
                   byte_or_serial_select_in, interface_type_select_in,
                   conv_start_group_b_in, conv_start_group_a_in,
                   sclk_in, rd_n_in, cs_n_in};

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_r <= `ARI_SYNC_RST;
      s2_r <= `ARI_SYNC_RST;
      s3_r <= `ARI_SYNC_RST;
      f_r  <= `ARI_SYNC_RST;
      fp_r <= `ARI_SYNC_RST;
    end else begin
      s1_r <= pins_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r  <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
      fp_r <= f_r;
    end
  end

  logic       cs_f;
  logic       cs_fall;
  logic       cs_rise;
  logic       rd_fall;
  logic       sclk_fall;
  logic       ca_rise;
  logic       cb_rise;
  logic       it_f;
  logic       bs_f;
  logic       bo_f;
  logic [2:0] os_f;

  assign cs_f      = f_r[0];
  assign cs_fall   = fp_r[0] & ~f_r[0];
  assign cs_rise   = ~fp_r[0] & f_r[0];
  assign rd_fall   = fp_r[1] & ~f_r[1] & ~cs_f;
  assign sclk_fall = fp_r[2] & ~f_r[2] & ~cs_f;
  assign ca_rise   = ~fp_r[3] & f_r[3];
  assign cb_rise   = ~fp_r[4] & f_r[4];
  assign it_f      = f_r[5];
  assign bs_f      = f_r[6];
  assign bo_f      = f_r[7];
  assign os_f      = f_r[10:8];

  // Conversion sequencing and averaging filter.
  ari_pkg::ari_state_t st_r;
  logic                a_seen_r;
  logic                b_seen_r;
  logic                busy_r;
  logic [2:0]          osr_r;
  logic [15:0]         timer_r;
  logic [9:0]          samp_r;
  logic signed [23:0]  acc_r [`ARI_NUM_CH];
  logic [17:0]         res_r [`ARI_NUM_CH];
  logic [17:0]         fifo_data_w;
  logic                fifo_valid_w;
  logic                fifo_ready_w;
  logic                take_w;
  logic                go_w;
  logic [15:0]         conv_cyc_w;
  logic [9:0]          samp_tot_w;
  logic                timer_done_w;
  logic                samp_done_w;

  assign conv_cyc_w   = 16'(CONV_BASE_CYC << osr_r);
  assign samp_tot_w   = 10'(`ARI_NUM_CH << osr_r);
  assign timer_done_w = timer_r == conv_cyc_w - 16'h0001;
  assign samp_done_w  = samp_r == samp_tot_w;
  assign fifo_ready_w = (st_r == ari_pkg::ARI_ST_CONV) && !samp_done_w;
  assign take_w       = fifo_ready_w && fifo_valid_w;
  assign go_w = (st_r == ari_pkg::ARI_ST_IDLE) &&
                (a_seen_r || ca_rise) && (b_seen_r || cb_rise);

  ari_fifo #(
    .WIDTH (`ARI_RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .reset_in      (reset_in),
    .in_data_in    (conv_data_in),
    .in_valid_in   (conv_valid_in),
    .in_ready_out  (conv_ready_out),
    .out_data_out  (fifo_data_w),
    .out_valid_out (fifo_valid_w),
    .out_ready_in  (fifo_ready_w)
  );

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r   <= ari_pkg::ARI_ST_IDLE;
      busy_r <= 1'b0;
    end else begin
      case (st_r)
        ari_pkg::ARI_ST_IDLE: begin
          if (go_w) begin
            st_r   <= ari_pkg::ARI_ST_CONV;
            busy_r <= 1'b1;
          end
        end
        ari_pkg::ARI_ST_CONV: begin
          // Busy covers both the timed conversion and the sample intake,
          // so it stretches with the ratio and with a starved FIFO.
          if (timer_done_w && samp_done_w) begin
            st_r <= ari_pkg::ARI_ST_LOAD;
          end
        end
        ari_pkg::ARI_ST_LOAD: begin
          st_r   <= ari_pkg::ARI_ST_IDLE;
          busy_r <= 1'b0;
        end
        default: begin
          st_r   <= ari_pkg::ARI_ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      a_seen_r <= 1'b0;
      b_seen_r <= 1'b0;
    end else if (go_w) begin
      a_seen_r <= 1'b0;
      b_seen_r <= 1'b0;
    end else if (st_r == ari_pkg::ARI_ST_IDLE) begin
      a_seen_r <= a_seen_r | ca_rise;
      b_seen_r <= b_seen_r | cb_rise;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      timer_r <= 16'h0000;
      samp_r  <= 10'h000;
    end else if (go_w) begin
      timer_r <= 16'h0000;
      samp_r  <= 10'h000;
    end else if (st_r == ari_pkg::ARI_ST_CONV) begin
      if (!timer_done_w) begin
        timer_r <= timer_r + 16'h0001;
      end
      if (take_w) begin
        samp_r <= samp_r + 10'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < `ARI_NUM_CH; i++) begin
        acc_r[i] <= 24'sh000000;
      end
    end else if (go_w) begin
      for (int i = 0; i < `ARI_NUM_CH; i++) begin
        acc_r[i] <= 24'sh000000;
      end
    end else if (take_w) begin
      acc_r[samp_r[2:0]] <= acc_r[samp_r[2:0]] +
                            24'(signed'(fifo_data_w));
    end
  end

  // Results change only in the load cycle, so any read while busy is
  // high sees the previous sample set.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < `ARI_NUM_CH; i++) begin
        res_r[i] <= 18'h00000;
      end
    end else if (st_r == ari_pkg::ARI_ST_LOAD) begin
      for (int i = 0; i < `ARI_NUM_CH; i++) begin
        res_r[i] <= 18'(acc_r[i] >>> osr_r);
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osr_r <= 3'h0;
    end else if (st_r == ari_pkg::ARI_ST_LOAD) begin
      // The reserved pin code seven falls back to no oversampling.
      osr_r <= (os_f == 3'h7) ? 3'h0 : os_f;
    end
  end

  assign busy_out = busy_r;

  // Readout frame configuration, caught at select fall from levels that
  // were stable while select was high.
  ari_pkg::ari_mode_t mode_r;
  ari_pkg::ari_mode_t frame_mode_w;
  logic               order_r;
  logic               word_mode_r;

  assign frame_mode_w = cs_fall ? ari_decode(it_f, bs_f) : mode_r;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_r      <= ari_pkg::ARI_MODE_WORD;
      order_r     <= 1'b1;
      word_mode_r <= 1'b0;
    end else begin
      word_mode_r <= !it_f;
      if (cs_fall) begin
        mode_r  <= ari_decode(it_f, bs_f);
        order_r <= bo_f;
      end
    end
  end

  assign word_mode_out = word_mode_r;

  // Byte-wide readout.
  logic [7:0] byte_r;
  logic       byte_oe_r;
  logic [1:0] bk_r;
  logic [2:0] bch_r;
  logic       byte_rd_w;

  assign byte_rd_w = rd_fall && (mode_r == ari_pkg::ARI_MODE_BYTE);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      byte_r    <= 8'h00;
      byte_oe_r <= 1'b0;
      bk_r      <= 2'h0;
      bch_r     <= 3'h0;
    end else if (cs_rise) begin
      byte_oe_r <= 1'b0;
    end else if (cs_fall && frame_mode_w == ari_pkg::ARI_MODE_BYTE) begin
      byte_oe_r <= 1'b1;
      bk_r      <= 2'h0;
      bch_r     <= 3'h0;
    end else if (byte_rd_w) begin
      byte_r <= ari_pick_byte(res_r[bch_r], bk_r,
                              order_r);
      if (bk_r == 2'h2) begin
        bk_r  <= 2'h0;
        bch_r <= bch_r + 3'h1;
      end else begin
        bk_r <= bk_r + 2'h1;
      end
    end
  end

  assign byte_bus_out    = byte_r;
  assign byte_bus_oe_out = byte_oe_r;

  // Serial readout; the channel pointer survives select pulses so the
  // host may frame each channel on its own.
  logic       sda_r;
  logic       sdb_r;
  logic       ser_oe_r;
  logic [4:0] sbit_r;
  logic [2:0] sch_r;
  logic [2:0] sch_nxt;
  logic       ser_clk_w;

  assign sch_nxt   = sch_r + 3'h1;
  assign ser_clk_w = sclk_fall && (mode_r == ari_pkg::ARI_MODE_SERIAL);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sda_r    <= 1'b0;
      sdb_r    <= 1'b0;
      ser_oe_r <= 1'b0;
      sbit_r   <= 5'h00;
      sch_r    <= 3'h0;
    end else if (cs_rise) begin
      ser_oe_r <= 1'b0;
      if (st_r == ari_pkg::ARI_ST_LOAD) begin
        sch_r  <= 3'h0;
        sbit_r <= 5'h00;
      end
    end else if (st_r == ari_pkg::ARI_ST_LOAD) begin
      sch_r  <= 3'h0;
      sbit_r <= 5'h00;
    end else if (cs_fall &&
                 frame_mode_w == ari_pkg::ARI_MODE_SERIAL) begin
      ser_oe_r <= 1'b1;
      sbit_r   <= 5'h00;
      sda_r    <= ari_bit(res_r[sch_r], 5'h00);
      sdb_r    <= ari_bit(res_r[sch_r ^ 3'h4], 5'h00);
    end else if (ser_clk_w) begin
      if (sbit_r == 5'd17) begin
        sbit_r <= 5'h00;
        sch_r  <= sch_nxt;
        sda_r  <= ari_bit(res_r[sch_nxt], 5'h00);
        sdb_r  <= ari_bit(res_r[sch_nxt ^ 3'h4], 5'h00);
      end else begin
        sbit_r <= sbit_r + 5'h01;
        sda_r  <= ari_bit(res_r[sch_r], sbit_r + 5'h01);
        sdb_r  <= ari_bit(res_r[sch_r ^ 3'h4], sbit_r + 5'h01);
      end
    end
  end

  assign serial_out_line_a_out = sda_r;
  assign serial_out_line_b_out = sdb_r;
  assign serial_oe_out         = ser_oe_r;

  // First-channel flag, shared by both modes.
  logic flag_r;
  logic flag_oe_r;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_r    <= 1'b0;
      flag_oe_r <= 1'b0;
    end else if (cs_rise) begin
      flag_r    <= 1'b0;
      flag_oe_r <= 1'b0;
    end else if (cs_fall && frame_mode_w != ari_pkg::ARI_MODE_WORD) begin
      flag_oe_r <= 1'b1;
      flag_r    <= (frame_mode_w == ari_pkg::ARI_MODE_SERIAL) &&
                   (sch_r == 3'h0);
    end else if (byte_rd_w) begin
      flag_r <= bch_r == 3'h0;
    end else if (ser_clk_w && sbit_r == 5'd17) begin
      flag_r <= sch_nxt == 3'h0;
    end
  end

  assign first_channel_flag_out    = flag_r;
  assign first_channel_flag_oe_out = flag_oe_r;

  chk_byte_mode_enter: assert property (
    cs_fall && it_f && bs_f |=> byte_oe_r && !ser_oe_r && flag_oe_r)
    else $error("byte mode not entered");
  chk_serial_enter: assert property (
    cs_fall && it_f && !bs_f |=> ser_oe_r && !byte_oe_r && flag_oe_r)
    else $error("serial mode not entered");
  chk_word_mode_idle: assert property (
    cs_fall && !it_f && cs_f == 1'b0 ##1 cs_f == 1'b0 |->
      !byte_oe_r && !ser_oe_r && word_mode_r)
    else $error("word mode drove byte or serial lines");
  chk_byte_first_val: assert property (
    byte_rd_w && bch_r == 3'h0 && bk_r == 2'h0 && order_r |=>
      byte_bus_out == res_r[0][17:10])
    else $error("first byte wrong");
  chk_flag_byte_fourth: assert property (
    byte_rd_w && bch_r == 3'h1 && bk_r == 2'h0 |=> !flag_r)
    else $error("flag not low at fourth strobe");
  chk_flag_byte_rise: assert property (
    byte_rd_w && bch_r == 3'h0 |=> flag_r)
    else $error("flag not high for channel one");
  chk_serial_idle: assert property (
    cs_f && $past(cs_f) |-> !ser_oe_r && !flag_oe_r)
    else $error("outputs driven with select high");
  chk_serial_msb: assert property (
    cs_fall && frame_mode_w == ari_pkg::ARI_MODE_SERIAL &&
    st_r != ari_pkg::ARI_ST_LOAD |=>
      sda_r == res_r[sch_r][17] && sdb_r == res_r[sch_r ^ 3'h4][17])
    else $error("serial MSB wrong");
  chk_flag_serial_end: assert property (
    ser_clk_w && sbit_r == 5'd17 && sch_r == 3'h0 |=> !flag_r)
    else $error("flag not low at 18th clock");
  chk_osr_latch: assert property (
    $fell(busy_r) |-> osr_r == (($past(os_f) == 3'h7) ? 3'h0 : $past(os_f)))
    else $error("ratio not latched at busy fall");
  chk_load_before_fall: assert property (
    $fell(busy_r) |-> $past(st_r) == ari_pkg::ARI_ST_LOAD)
    else $error("busy fell without result load");
  chk_busy_length: assert property (
    st_r == ari_pkg::ARI_ST_LOAD |-> timer_r == conv_cyc_w - 16'h0001)
    else $error("conversion time short");
  chk_read_prev: assert property (
    st_r == ari_pkg::ARI_ST_CONV |=> $stable(res_r[0]))
    else $error("results changed during conversion");
  chk_start_both: assert property (
    $rose(busy_r) |-> $past(a_seen_r || ca_rise) && $past(b_seen_r || cb_rise))
    else $error("busy rose without both starts");
endmodule : ari_readout

// File: ari_host_model.sv
// Host model: drives chip select, read strobe and serial clock.
// Assumes the block samples these pins on its own system clock.
`timescale 1ns/1ps
module ari_host_model (
  // Clock
  input  wire logic sys_clk_in,
  // Host strobes
  output logic      cs_n_out,
  output logic      rd_n_out,
  output logic      sclk_out
);
  // Levels are held eight cycles, four per serial clock phase, so the pin filter always sees them.
  localparam int HOLD = 8;
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    sclk_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : hold
  // One frame for all channels or one per channel are both legal in serial mode; a new byte frame restarts at channel one.
  task automatic select(input logic lvl);
    cs_n_out = lvl;
    hold(HOLD);
  endtask : select
  task automatic rd_pulse();
    rd_n_out = 1'b0;
    hold(HOLD);
    rd_n_out = 1'b1;
    hold(HOLD);
  endtask : rd_pulse
  // The serial clock idles high and toggles only when asked.
  task automatic sclk_pulse();
    sclk_out = 1'b0;
    hold(HOLD / 2);
    sclk_out = 1'b1;
    hold(HOLD / 2);
  endtask : sclk_pulse
endmodule : ari_host_model

// File: testbench.sv
// Self-checking bench for the converter result readout block.
// Assumes the host model drives the strobes; the bench feeds samples.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk_in, reset_in;
  logic [17:0] conv_data;
  logic        conv_valid, conv_ready, st_a, st_b, busy;
  logic [2:0]  os_pins;
  logic        itype, bsel, border, word_mode, cs_n, rd_n, sclk;
  logic [7:0]  byte_bus;
  logic        byte_oe, line_a, line_b, ser_oe, flag, flag_oe;
  logic [17:0] exp_v [8];
  int          bad_count = 0, comparisons = 0, cycles = 0;
  int          t0, len1, len2, len3;

  ari_readout #(.CONV_BASE_CYC(100)) i_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .conv_data_in(conv_data), .conv_valid_in(conv_valid),
    .conv_ready_out(conv_ready), .conv_start_group_a_in(st_a),
    .conv_start_group_b_in(st_b), .oversample_ratio_pins_in(os_pins),
    .busy_out(busy), .interface_type_select_in(itype),
    .byte_or_serial_select_in(bsel), .byte_order_control_in(border),
    .word_mode_out(word_mode), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .sclk_in(sclk), .byte_bus_out(byte_bus), .byte_bus_oe_out(byte_oe),
    .serial_out_line_a_out(line_a), .serial_out_line_b_out(line_b),
    .serial_oe_out(ser_oe), .first_channel_flag_out(flag),
    .first_channel_flag_oe_out(flag_oe));
  ari_host_model i_host (.sys_clk_in(sys_clk_in), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .sclk_out(sclk));

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  function automatic logic [17:0] ch_val(input int k);
    return 18'h34567 ^ {k[3:0], 14'h0A5A};
  endfunction : ch_val
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [17:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic push(input int n, input logic inv);
    for (int i = 0; i < n; i++) begin
      conv_data = (inv && i >= 8) ? ~ch_val(i % 8) : ch_val(i % 8);
      conv_valid = 1'b1;
      while (conv_ready !== 1'b1) step(1);
      step(1);
    end
    conv_valid = 1'b0;
  endtask : push
  // A split start raises group A alone first, which must not start work.
  task automatic conv_start(input logic split = 1'b0);
    if (split) begin
      st_a = 1'b1;
      step(8);
      chk("busy", 1'b0, busy);
    end
    st_a = 1'b1;
    st_b = 1'b1;
    step(8);
    chk("busy", 1'b1, busy);
    st_a = 1'b0;
    st_b = 1'b0;
    t0 = cycles;
  endtask : conv_start
  task automatic conv_end(output int len);
    while (busy === 1'b1 && cycles - t0 < 1000) step(1);
    len = cycles - t0;
    chk("busy", 1'b0, busy);
  endtask : conv_end
  task automatic byte_read(input logic ord, input int n);
    logic [23:0] w;
    int j;
    i_host.select(1'b0);
    chk("byte_bus_oe", 1'b1, byte_oe);
    chk("flag", 1'b0, flag);
    for (int s = 0; s < n; s++) begin
      i_host.rd_pulse();
      w = {exp_v[(s / 3) % 8], 6'h00};
      j = ord ? 2 - s % 3 : s % 3;
      chk("byte_bus", w[j * 8 +: 8], byte_bus);
      chk("flag", s < 3, flag);
    end
    i_host.select(1'b1);
    chk("byte_bus_oe", 1'b0, byte_oe);
    chk("flag_oe", 1'b0, flag_oe);
  endtask : byte_read
  task automatic ser_read(input int p0, nch, nb);
    int p;
    i_host.select(1'b0);
    chk("serial_oe", 1'b1, ser_oe);
    for (int c = 0; c < nch; c++) begin
      p = (p0 + c) % 8;
      for (int b = 17; b >= 0; b--) begin
        if (b >= 18 - nb) begin
          chk("line_a", exp_v[p][b], line_a);
          chk("line_b", exp_v[p ^ 4][b], line_b);
          chk("flag", p == 0, flag);
          i_host.sclk_pulse();
        end else if (c < nch - 1) begin
          i_host.sclk_pulse();
        end
      end
    end
    i_host.select(1'b1);
    chk("serial_oe", 1'b0, ser_oe);
    chk("flag_oe", 1'b0, flag_oe);
  endtask : ser_read

  initial begin
    reset_in = 1'b1;
    conv_data = 18'h00000;
    conv_valid = 1'b0;
    st_a = 1'b0;
    st_b = 1'b0;
    os_pins = 3'h0;
    itype = 1'b0;
    bsel = 1'b1;
    border = 1'b1;
    step(16);
    reset_in = 1'b0;
    step(8);
    chk("word_mode", 1'b1, word_mode);
    i_host.select(1'b0);
    chk("byte_bus_oe", 1'b0, byte_oe);
    i_host.select(1'b1);
    itype = 1'b1;
    step(8);
    chk("word_mode", 1'b0, word_mode);
    push(8, 1'b0);
    conv_start(1'b1);
    os_pins = 3'h1;
    conv_end(len1);
    for (int k = 0; k < 8; k++) exp_v[k] = ch_val(k);
    byte_read(1'b1, 24);
    border = 1'b0;
    step(8);
    byte_read(1'b0, 3);
    bsel = 1'b0;
    step(8);
    ser_read(0, 2, 18);
    i_host.sclk_pulse();
    chk("line_b", exp_v[6][17], line_b);
    ser_read(2, 1, 18);
    // The read during busy ends long before busy falls.
    push(16, 1'b1);
    conv_start();
    os_pins = 3'h2;
    ser_read(3, 1, 6);
    conv_end(len2);
    chk("busy_longer", 1'b1, len2 > len1);
    for (int k = 0; k < 8; k++) exp_v[k] = 18'h3FFFF;
    bsel = 1'b1;
    border = 1'b1;
    step(8);
    byte_read(1'b1, 6);
    push(32, 1'b0);
    chk("conv_ready", 1'b0, conv_ready);
    conv_start();
    os_pins = 3'h0;
    conv_end(len3);
    chk("busy_longer", 1'b1, len3 > len2);
    chk("conv_ready", 1'b1, conv_ready);
    for (int k = 0; k < 8; k++) exp_v[k] = ch_val(k);
    byte_read(1'b1, 6);
    print_verdict();
  end
endmodule : testbench
